// File: hw/blc_loop.sv
`timescale 1ns/1ps
// Contract
// - Disabled loop leaves offset register software-owned
// - Enabled loop rewrites offset once per line
// - Reference select: 01 shift, 10 clamp
// - Window starts position plus one pixels after reference
// - Average 4, 8, 16 or 32 pixels
// - Target compares converter output above four LSBs
// - Error is target minus average
// - Correction is error over 8..64
// - Line field: 15, 31, 63 or unlimited
// - Stop updates after programmed line count
// - Unlimited setting updates every line
// - Range bounded only by offset register width
module blc_loop
  import blc_pkg::*;
#(
  parameter int ADC_W = 16,
  parameter int TARGET_W = 10,
  parameter int OFS_W = 10
)(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire blc_reg_wr_t regWr,
  input wire logic [7:0] regRdAddr,
  output logic [7:0] regRdData,
  input wire logic loopEnable,
  input wire logic [TARGET_W-1:0] targetLevel,
  input wire logic ofsWr,
  input wire logic signed [OFS_W-1:0] ofsWrData,
  input wire logic scanStart,
  input wire logic pixelValid,
  input wire logic [ADC_W-1:0] adcData,
  input wire logic shift_gate_pulse,
  input wire logic external_clamp_input,
  output logic signed [OFS_W-1:0] offsetDac,
  output logic black_window_pulse,
  output logic loopActive,
  output logic updateDone
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  // Coarse converter scale must cover the whole target range
  if (ADC_W < TARGET_W + BLC_TARGET_SHIFT) begin : g_bad_adc
    $error("ADC_W too small for target width");
  end
  // Saturation needs a sign bit and at least one magnitude bit
  if (OFS_W < 2) begin : g_bad_ofs
    $error("OFS_W too small");
  end

  // Converter code without its four ignored LSBs; one target step each
  localparam int COARSE_W = ADC_W - BLC_TARGET_SHIFT;
  // Sum of up to 32 coarse codes needs five extra bits
  localparam int ACC_W = COARSE_W + 5;
  // Signed difference of two coarse codes
  localparam int ERR_W = COARSE_W + 1;
  // One guard bit so the clamp sees the true sum
  localparam int SUM_W = (OFS_W > ERR_W ? OFS_W : ERR_W) + 1;
  // Two's complement limits of the offset code
  localparam logic signed [OFS_W-1:0] OFS_MAX = {1'b0, {(OFS_W-1){1'b1}}};
  localparam logic signed [OFS_W-1:0] OFS_MIN = {1'b1, {(OFS_W-1){1'b0}}};

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] controlReg_q;
  logic [7:0] positionReg_q;
  logic selControl;
  logic selPosition;

  // Only the two clamp registers exist; other offsets are ignored
  assign selControl = regWr.wr && (regWr.addr == BLC_OFS_CLAMP_CONTROL);
  assign selPosition = regWr.wr && (regWr.addr == BLC_OFS_CLAMP_POSITION);

  // Register writes
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      controlReg_q <= BLC_RST_CONTROL;
      positionReg_q <= BLC_RST_POSITION;
    end else begin
      if (selControl) begin
        controlReg_q <= regWr.data;
      end
      if (selPosition) begin
        positionReg_q <= regWr.data;
      end
    end
  end

  // Field decode
  logic [1:0] refSel;
  logic [1:0] integSel;
  logic [1:0] avgSel;
  logic [1:0] linesSel;
  assign refSel = controlReg_q[BLC_REF_LSB +: 2];
  assign integSel = controlReg_q[BLC_INTEG_LSB +: 2];
  assign avgSel = controlReg_q[BLC_AVG_LSB +: 2];
  assign linesSel = controlReg_q[BLC_LINES_LSB +: 2];

  // Read mux; unmapped offsets read zero
  logic [7:0] rdMux;
  assign rdMux = (regRdAddr == BLC_OFS_CLAMP_CONTROL) ? controlReg_q :
                 (regRdAddr == BLC_OFS_CLAMP_POSITION) ? positionReg_q : 8'h00;

  // ****************************************
  // Reference edge select
  // ****************************************
  logic shiftFall;
  logic clampFall;
  logic refFall;

  // Both detectors always run; the select only picks one
  blc_edge_detect u_shift_edge (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .level(shift_gate_pulse),
    .fall(shiftFall)
  );

  blc_edge_detect u_clamp_edge (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .level(external_clamp_input),
    .fall(clampFall)
  );

  // Codes 00 and 11 select no reference, so the window never opens
  logic refIsShift;
  logic refIsClamp;
  assign refIsShift = (refSel == BLC_REF_SHIFT);
  assign refIsClamp = (refSel == BLC_REF_CLAMP);
  assign refFall = (refIsShift && shiftFall) || (refIsClamp && clampFall);

  // ****************************************
  // Line limit
  // ****************************************
  logic [5:0] lineCnt_q;
  logic [5:0] lineLimit;
  logic lineLimitHit;
  assign lineLimit = (linesSel == 2'h0) ? BLC_LINES_15 :
                     (linesSel == 2'h1) ? BLC_LINES_31 : BLC_LINES_63;
  // Counter saturates at 63, so it never wraps back under a limit
  // Unlimited never hits the limit
  assign lineLimitHit = (linesSel != BLC_LINES_INF) && (lineCnt_q >= lineLimit);

  // ****************************************
  // Window and averaging state machine
  // ****************************************
  // Per-line window state, delay and pixel counters, running sum
  blc_state_t state_q;
  blc_state_t state_d;
  logic [7:0] delayCnt_q;
  logic [5:0] pixCnt_q;
  logic [ACC_W-1:0] acc_q;
  logic [5:0] avgCount;
  logic [COARSE_W-1:0] adcCoarse;
  logic lastPixel;
  logic delayDone;

  // Window size, coarse pixel code and step conditions
  assign avgCount = 6'(1 << (BLC_AVG_BASE_LOG + 32'(avgSel)));
  assign adcCoarse = adcData[ADC_W-1:BLC_TARGET_SHIFT];
  assign lastPixel = pixelValid && (pixCnt_q == avgCount - 6'h01);
  assign delayDone = pixelValid && (delayCnt_q >= positionReg_q);

  // Timing of one line:
  //   edge 0   selected reference falls, detector fires at once
  //   edge 1   DELAY; each pixel strobe steps the delay count
  //   pos+1    strobe with count at position opens the window
  //   window   the next avgCount strobes are summed
  //   +1       UPDATE for one cycle, offset and strobe follow
  // A reference edge seen outside IDLE is ignored, so a second
  // edge inside a long window cannot cut the average short.
  // Next-state; a reference edge starts a window only from IDLE
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      BLC_IDLE: begin
        if (refFall && loopEnable && !lineLimitHit) begin
          state_d = BLC_DELAY;
        end
      end
      BLC_DELAY: begin
        if (delayDone) begin
          state_d = BLC_ACCUM;
        end
      end
      BLC_ACCUM: begin
        if (lastPixel) begin
          state_d = BLC_UPDATE;
        end
      end
      BLC_UPDATE: begin
        state_d = BLC_IDLE;
      end
    endcase
    // Disable or a new scan aborts any window in flight
    if (!loopEnable || scanStart) begin
      state_d = BLC_IDLE;
    end
  end

  // Counters track pixel periods, not clock cycles
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= BLC_IDLE;
      delayCnt_q <= 8'h00;
      pixCnt_q <= 6'h00;
      acc_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == BLC_IDLE) begin
        delayCnt_q <= 8'h00;
        pixCnt_q <= 6'h00;
        acc_q <= '0;
      end else if (state_q == BLC_DELAY && pixelValid && !delayDone) begin
        delayCnt_q <= delayCnt_q + 8'h01;
      end else if (state_q == BLC_ACCUM && pixelValid) begin
        pixCnt_q <= pixCnt_q + 6'h01;
        acc_q <= acc_q + ACC_W'(adcCoarse);
      end
    end
  end

  // ****************************************
  // Error and scaled correction
  // ****************************************
  logic [COARSE_W-1:0] average;
  logic signed [ERR_W-1:0] errorVal;
  logic signed [ERR_W-1:0] corr;
  logic signed [SUM_W-1:0] sumVal;
  logic signed [OFS_W-1:0] offsetNext;

  // Divide by pixel count via shift; count is a power of two
  assign average = COARSE_W'(acc_q >> (BLC_AVG_BASE_LOG + 32'(avgSel)));
  // Target zero-extended onto the coarse scale: one step is sixteen codes
  assign errorVal = $signed(ERR_W'(targetLevel)) - $signed(ERR_W'(average));
  // Arithmetic shift keeps the sign of the error
  assign corr = errorVal >>> (BLC_DIV_BASE_LOG + 32'(integSel));
  assign sumVal = SUM_W'(offsetDac) + SUM_W'(corr);
  // Clamp rather than wrap, so a large error never flips polarity
  logic satHigh;
  logic satLow;
  assign satHigh = (sumVal > SUM_W'(OFS_MAX));
  assign satLow = (sumVal < SUM_W'(OFS_MIN));
  assign offsetNext = satHigh ? OFS_MAX :
                      satLow ? OFS_MIN :
                      OFS_W'(sumVal);

  logic doUpdate;
  assign doUpdate = (state_q == BLC_UPDATE) && loopEnable && !lineLimitHit;

  // Offset register; software write only honoured while loop is off
  // Loop update and software write can never meet, enable splits them
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      offsetDac <= '0;
    end else if (doUpdate) begin
      offsetDac <= offsetNext;
    end else if (ofsWr && !loopEnable) begin
      offsetDac <= ofsWrData;
    end
  end

  // Line counter counts updated lines since scan start
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      lineCnt_q <= 6'h00;
    end else if (scanStart) begin
      lineCnt_q <= 6'h00;
    end else if (state_q == BLC_UPDATE && lineCnt_q != BLC_LINES_63) begin
      lineCnt_q <= lineCnt_q + 6'h01;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  // Window pulse comes from the next state, so it lines up with the
  // first summed strobe; read data lags its address by one cycle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
      black_window_pulse <= 1'b0;
      loopActive <= 1'b0;
      updateDone <= 1'b0;
    end else begin
      regRdData <= rdMux;
      black_window_pulse <= (state_d == BLC_ACCUM);
      loopActive <= loopEnable && !lineLimitHit;
      updateDone <= doUpdate;
    end
  end

endmodule

// File: include/blc_pkg.sv
package blc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] BLC_OFS_CLAMP_CONTROL = 8'h08;
  localparam logic [7:0] BLC_OFS_CLAMP_POSITION = 8'h09;
  localparam logic [7:0] BLC_RST_CONTROL = 8'h00;
  localparam logic [7:0] BLC_RST_POSITION = 8'h00;

  // ****************************************
  // Control field positions
  // ****************************************
  localparam int BLC_REF_LSB = 0;
  localparam int BLC_INTEG_LSB = 2;
  localparam int BLC_AVG_LSB = 4;
  localparam int BLC_LINES_LSB = 6;

  localparam logic [1:0] BLC_REF_SHIFT = 2'h1;
  localparam logic [1:0] BLC_REF_CLAMP = 2'h2;
  localparam logic [1:0] BLC_LINES_INF = 2'h3;

  // Line limits for 15/31/63 settings
  localparam logic [5:0] BLC_LINES_15 = 6'h0f;
  localparam logic [5:0] BLC_LINES_31 = 6'h1f;
  localparam logic [5:0] BLC_LINES_63 = 6'h3f;

  // Target step is sixteen converter codes
  localparam int BLC_TARGET_SHIFT = 4;
  // Smallest averaging count is 4 = 2**2, smallest divider 8 = 2**3
  localparam int BLC_AVG_BASE_LOG = 2;
  localparam int BLC_DIV_BASE_LOG = 3;

  typedef enum logic [1:0] {
    BLC_IDLE,
    BLC_DELAY,
    BLC_ACCUM,
    BLC_UPDATE
  } blc_state_t;

  // Register write strobe with its data
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } blc_reg_wr_t;

endpackage

// File: hw/blc_edge_detect.sv
`timescale 1ns/1ps
// ****************************************
// Falling edge detector for reference pulses
// ****************************************
module blc_edge_detect
  import blc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic level,
  output logic fall
);

  logic prev_q;

  // Registered previous level
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level;
    end
  end

  // One-cycle pulse on high-to-low transition
  assign fall = prev_q & ~level;

endmodule

// File: verif/blc_loop_monitor.sv
`timescale 1ns/1ps
// ********
// Checker
// ********
module blc_loop_monitor
  import blc_pkg::*;
#(parameter int ADC_W = 16, parameter int TARGET_W = 10, parameter int OFS_W = 10)(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire blc_reg_wr_t regWr,
  input wire logic loopEnable,
  input wire logic ofsWr,
  input wire logic signed [OFS_W-1:0] ofsWrData,
  input wire logic scanStart,
  input wire logic pixelValid,
  input wire logic signed [OFS_W-1:0] offsetDac,
  input wire logic black_window_pulse,
  input wire logic updateDone
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [7:0] ctlQ;
  logic [5:0] updQ;
  logic [5:0] winQ;
  logic [1:0] avgQ;
  wire [5:0] lim = ctlQ[7:6] == 2'h0 ? BLC_LINES_15 :
                   ctlQ[7:6] == 2'h1 ? BLC_LINES_31 : BLC_LINES_63;
  // Shadow control; count updates since scan start and window pixels
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctlQ <= '0;
      updQ <= '0;
      winQ <= '0;
      avgQ <= '0;
    end else begin
      if (regWr.wr && regWr.addr == BLC_OFS_CLAMP_CONTROL) ctlQ <= regWr.data;
      if (scanStart) updQ <= '0;
      else if (updateDone && updQ != 6'h3f) updQ <= updQ + 6'h01;
      winQ <= !black_window_pulse ? 6'h00 : winQ + 6'(pixelValid);
      // Size latched while idle, so a mid-window write is not misread
      if (!black_window_pulse) avgQ <= ctlQ[5:4];
    end
  end
  sequence offLong;
    (!loopEnable) [*3];
  endsequence
  off_quiet_a: assert property (offLong |-> !updateDone) else $error("update when off");
  ofs_hold_a: assert property (offLong ##0 !ofsWr |=> $stable(offsetDac)) else $error("drift");
  ofs_load_a: assert property (!loopEnable && ofsWr |=> offsetDac == $past(ofsWrData))
    else $error("offset write lost");
  upd_pulse_a: assert property (updateDone |=> !updateDone) else $error("long update");
  dac_cause_a: assert property ($changed(offsetDac) |-> updateDone || $past(ofsWr))
    else $error("offset changed without cause");
  win_len_a: assert property ($fell(black_window_pulse) && !$past(scanStart) &&
    $past(loopEnable) |-> winQ == (6'd4 << avgQ)) else $error("window pixel count");
  upd_src_a: assert property (updateDone |-> $past(black_window_pulse, 2)) else $error("no window");
  lim_stop_a: assert property (ctlQ[7:6] != BLC_LINES_INF && updQ >= lim |-> !updateDone)
    else $error("update past line limit");
endmodule

// File: verif/blc_sensor_model.sv
`timescale 1ns/1ps
// ********
// Sensor line source
// ********
module blc_sensor_model (
  input wire logic clk_sys,
  input wire logic [15:0] level,
  output logic shift_gate_pulse = 1'b0,
  output logic external_clamp_input = 1'b0,
  output logic pixelValid = 1'b0,
  output logic [15:0] adcData = 16'h0000
);
  int t = 0;
  // 100-cycle line, one pixel every second cycle
  always @(posedge clk_sys) begin
    t <= (t == 99) ? 0 : t + 1;
    shift_gate_pulse <= t < 2;
    external_clamp_input <= t >= 96 && t < 98; // clamp clear of every window
    pixelValid <= t[0];
    adcData <= t[0] ? level : ~adcData; // Off-pixel data toggles
  end
endmodule

// File: verif/blc_loop_tb.sv
`timescale 1ns/1ps
module blc_loop_tb
  import blc_pkg::*;
;
  logic clk_sys = 0, sys_rst = 1, loopEnable = 0, ofsWr = 0, scanStart = 0;
  blc_reg_wr_t regWr = '0;
  logic [7:0] regRdAddr = '0, regRdData;
  logic [9:0] targetLevel = '0;
  logic signed [9:0] ofsWrData = '0, offsetDac;
  logic pixelValid, shift_gate_pulse, external_clamp_input, black_window_pulse;
  logic loopActive, updateDone;
  logic [15:0] adcData, level = '0;
  logic [31:0] rs = 32'hdc3b_ab4b;
  int err_count = 0, num_checks = 0, n, ofs, pv, pos;
  logic refPrev, refNow, bwpPrev;
  blc_loop dut_u (.*);
  blc_sensor_model sen_u (.*);
  initial forever #2 clk_sys = ~clk_sys;
  // ********
  // Helpers
  // ********
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWr <= '{1'b1, a, d};
    @(posedge clk_sys);
    regWr <= '0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk_sys);
    regRdAddr <= a;
    repeat (2) @(posedge clk_sys);
    chk(regRdData, x);
  endtask
  task automatic end_of_test();
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Run should take about 30k cycles; allow 50k
  initial begin
    #200us;
    err_count++;
    end_of_test();
  end
  // ********
  // Scenarios
  // ********
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 0;
    rreg(BLC_OFS_CLAMP_CONTROL, BLC_RST_CONTROL);
    rreg(BLC_OFS_CLAMP_POSITION, BLC_RST_POSITION);
    wreg(8'h0a, 8'h5a);
    rreg(8'h0a, 8'h00);
    ofs = $signed(rnd()) % 512;
    ofsWrData <= 10'(ofs);
    ofsWr <= 1;
    @(posedge clk_sys);
    ofsWr <= 0;
    @(posedge clk_sys);
    chk(offsetDac, 16'(ofs));
    // Each mode: line limit i, average 4<<i, divider 64>>i, alternating reference
    for (int i = 0; i < 4; i++) begin
      wreg(BLC_OFS_CLAMP_CONTROL, 8'(i * 80 + (3 - i) * 4 + 1 + i % 2));
      pos = rnd() % 4;
      wreg(BLC_OFS_CLAMP_POSITION, 8'(pos));
      targetLevel <= (i == 2) ? 10'h3ff : 10'(rnd());
      level <= (i == 2) ? 16'h0000 : 16'(rnd());
      ofsWrData <= 10'(rnd());
      ofsWr <= 1;
      scanStart <= 1;
      loopEnable <= 1;
      @(posedge clk_sys);
      scanStart <= 0;
      ofsWr <= 0;
      n = 0;
      pv = 0;
      refPrev = 1'b0;
      bwpPrev = 1'b0;
      repeat (7000) begin
        @(negedge clk_sys);
        // Pixel strobes from the reference fall to the window opening
        refNow = (i % 2 == 1) ? external_clamp_input : shift_gate_pulse;
        if (refPrev && !refNow) pv = 0;
        else if (!black_window_pulse && pixelValid) pv++;
        if (black_window_pulse && !bwpPrev) chk(16'(pv), 16'(pos + 1));
        refPrev = refNow;
        bwpPrev = black_window_pulse;
        if (updateDone === 1'b1) begin
          n++;
          ofs = ofs + ((int'(targetLevel) - int'(level[15:4])) >>> (6 - i));
          ofs = ofs > 511 ? 511 : ofs < -512 ? -512 : ofs;
          chk(offsetDac, 16'(ofs));
        end
      end
      if (i < 3) begin
        chk(16'(n), 16'((16 << i) - 1));
        chk({15'h0, loopActive}, 16'h0000);
      end else begin
        chk(16'(n > 63), 16'h0001);
        chk({15'h0, loopActive}, 16'h0001);
      end
      @(posedge clk_sys);
      loopEnable <= 0; // mode done, so turn the loop off
    end
    wreg(BLC_OFS_CLAMP_CONTROL, 8'hc0);
    scanStart <= 1;
    loopEnable <= 1;
    @(posedge clk_sys);
    scanStart <= 0;
    n = 0;
    repeat (500) begin
      @(negedge clk_sys);
      if (black_window_pulse === 1'b1) n++;
    end
    chk(16'(n), 16'h0000);
    rreg(BLC_OFS_CLAMP_CONTROL, 8'hc0);
    end_of_test();
  end
endmodule
bind blc_loop blc_loop_monitor #(.ADC_W(ADC_W), .TARGET_W(TARGET_W), .OFS_W(OFS_W)) mon_u (.*);
